// ---- shared/ipa_pkg.sv ----
// Constants and types for the in-application programming register block
package ipa_pkg;

   // ----------------------------------------------------------------
   // Bus and field widths
   // ----------------------------------------------------------------
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 8;
   localparam int NV_ADDR_W   = 15;
   localparam int HIGH_ADDR_W = 7;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_KEY   = 8'hF1;
   localparam logic [7:0] OFS_ADDRL = 8'hF2;
   localparam logic [7:0] OFS_ADDRH = 8'hF3;
   localparam logic [7:0] OFS_REGN  = 8'hF4;
   localparam logic [7:0] OFS_WDAT  = 8'hF5;
   localparam logic [7:0] OFS_CTL   = 8'hF6;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTL_BOOT_BIT  = 7;
   localparam int CTL_ERASE_BIT = 5;
   localparam int CTL_PROG_BIT  = 4;
   localparam int CTL_CMD_MSB   = 1;
   localparam int CTL_CMD_LSB   = 0;
   localparam logic [1:0] CMD_GO = 2'h2;

   // ----------------------------------------------------------------
   // Region selector codes, reset value and last key count
   // ----------------------------------------------------------------
   localparam logic [7:0] REGN_MAIN   = 8'h00;
   localparam logic [7:0] REGN_UID    = 8'h01;
   localparam logic [7:0] REGN_EEPROM = 8'h02;
   localparam logic [7:0] REGN_BOOT   = 8'h03;
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [7:0] KEY_LAST    = 8'h01;

   // ----------------------------------------------------------------
   // Operation engine states
   // ----------------------------------------------------------------
   typedef enum logic {
      ENG_IDLE,
      ENG_WAIT
   } ipa_eng_state_t;

endpackage : ipa_pkg

// ---- shared/ipa_op_if.sv ----
// Operation request carrier between register front end and engine
interface ipa_op_if;
   logic        start;
   logic        erase;
   logic        eeprom;
   logic [14:0] addr;
   logic [7:0]  wdata;
   logic        busy;

   modport ctl (output start, erase, eeprom, addr, wdata, input busy);
   modport eng (input start, erase, eeprom, addr, wdata, output busy);
endinterface : ipa_op_if

// ---- core/ipa_op_engine.sv ----
// Erase / program operation engine with processor stall
module ipa_op_engine
   import ipa_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   input  wire logic        ce_in,
   ipa_op_if.eng            op,
   input  wire logic        nv_done_in,
   output logic             nv_req_out,
   output logic             nv_erase_out,
   output logic             nv_eeprom_out,
   output logic [14:0]      nv_addr_out,
   output logic [7:0]       nv_wdata_out,
   output logic             cpu_stall_out
);

   ipa_eng_state_t state;

   assign op.busy = (state != ENG_IDLE);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state         <= ENG_IDLE;
         nv_req_out    <= 1'b0;
         cpu_stall_out <= 1'b0;
      end else if (ce_in) begin
         case (state)
            ENG_IDLE: begin
               if (op.start) begin
                  nv_req_out    <= 1'b1;
                  cpu_stall_out <= 1'b1;
                  state         <= ENG_WAIT;
               end
            end
            ENG_WAIT: begin
               nv_req_out <= 1'b0;
               // Done is only honoured here, so a stray early done is harmless
               if (nv_done_in) begin
                  cpu_stall_out <= 1'b0;
                  state         <= ENG_IDLE;
               end
            end
            default: begin
               nv_req_out    <= 1'b0;
               cpu_stall_out <= 1'b0;
               state         <= ENG_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Operation details, held stable for the whole operation
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         nv_erase_out  <= 1'b0;
         nv_eeprom_out <= 1'b0;
         nv_addr_out   <= '0;
         nv_wdata_out  <= RST_BYTE;
      end else if (ce_in && op.start && state == ENG_IDLE) begin
         nv_erase_out  <= op.erase;
         nv_eeprom_out <= op.eeprom;
         nv_addr_out   <= op.addr;
         nv_wdata_out  <= op.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_stall_on_start;
      @(posedge clock_in) disable iff (srst_in)
      (ce_in && op.start && state == ENG_IDLE) |=>
         (cpu_stall_out && nv_req_out);
   endproperty
   a_stall_on_start: assert property (p_stall_on_start)
      else $error("stall or request missing after start");

   property p_release_on_done;
      @(posedge clock_in) disable iff (srst_in)
      (ce_in && state == ENG_WAIT && nv_done_in) |=>
         (!cpu_stall_out && state == ENG_IDLE);
   endproperty
   a_release_on_done: assert property (p_release_on_done)
      else $error("stall not released on done");

   property p_hold_until_done;
      @(posedge clock_in) disable iff (srst_in)
      (cpu_stall_out && !nv_done_in) |=> cpu_stall_out;
   endproperty
   a_hold_until_done: assert property (p_hold_until_done)
      else $error("stall dropped before done");

   c_op_done: cover property (@(posedge clock_in) disable iff (srst_in)
      cpu_stall_out ##1 !cpu_stall_out);

endmodule : ipa_op_engine

// ---- core/ipa_regs.sv ----
// Register front end for in-application flash and data EEPROM programming
//
// Decided for this implementation: strobed register access.

// Summary of operation
// - Non-zero key write enables and loads limit
// - No command within n clocks disables function
// - Low address register gives target bits 7..0
// - High register gives bits 14..8; bit7 unused
// - Region 0x00 targets main code flash
// - Region 0x01 identifier area, read only
// - Region 0x02 targets independent data EEPROM
// - Region 0x03 boot area reads only; others reserved
// - Data register holds byte to program
// - Command code 10 starts single selected operation
// - Stall processor until operation completes
// - Boot select bit picks start area
module ipa_regs
   import ipa_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              srst_in,
   input  wire logic              ce_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wr_data_in,
   input  wire logic              wr_strobe_in,
   input  wire logic              rd_strobe_in,
   output logic       [DATA_W-1:0] rd_data_out,
   input  wire logic              nv_done_in,
   output logic                   nv_req_out,
   output logic                   nv_erase_out,
   output logic                   nv_eeprom_out,
   output logic       [14:0]      nv_addr_out,
   output logic       [7:0]       nv_wdata_out,
   output logic                   cpu_stall_out,
   output logic                   boot_area_select_out,
   output logic                   prog_enabled_out,
   output logic       [1:0]       table_region_out,
   output logic                   table_region_ok_out
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0]             key_count;
   logic                   prog_enabled;
   logic [7:0]             target_address_low;
   logic [HIGH_ADDR_W-1:0] target_address_high;
   logic [7:0]             region_select;
   logic [7:0]             program_write_data;
   logic                   boot_area_select;
   logic                   sector_erase_request;
   logic                   byte_program_request;
   logic [1:0]             cmd_field;

   ipa_op_if op ();

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic                 wr_key;
   logic                 wr_addrl;
   logic                 wr_addrh;
   logic                 wr_regn;
   logic                 wr_wdat;
   logic                 wr_ctl;
   logic                 cmd_go;
   logic                 want_erase;
   logic                 want_prog;
   logic                 writable_region;
   logic                 start_op;
   logic [NV_ADDR_W-1:0] nv_target_address;

   assign wr_key   = ce_in && wr_strobe_in && addr_in == OFS_KEY;
   assign wr_addrl = ce_in && wr_strobe_in && addr_in == OFS_ADDRL;
   assign wr_addrh = ce_in && wr_strobe_in && addr_in == OFS_ADDRH;
   assign wr_regn  = ce_in && wr_strobe_in && addr_in == OFS_REGN;
   assign wr_wdat  = ce_in && wr_strobe_in && addr_in == OFS_WDAT;
   assign wr_ctl   = ce_in && wr_strobe_in && addr_in == OFS_CTL;

   // Operation bits may be set earlier or in the same write as the code
   assign cmd_go = wr_ctl &&
                   wr_data_in[CTL_CMD_MSB:CTL_CMD_LSB] == CMD_GO;
   assign want_erase = sector_erase_request | wr_data_in[CTL_ERASE_BIT];
   assign want_prog  = byte_program_request | wr_data_in[CTL_PROG_BIT];

   assign writable_region = region_select == REGN_MAIN ||
                            region_select == REGN_EEPROM;

   // Identifier, boot and reserved regions never reach the engine
   assign start_op = cmd_go && prog_enabled && writable_region &&
                     (want_erase ^ want_prog) && !op.busy;

   assign nv_target_address = {target_address_high,
                               target_address_low};

   assign op.start  = start_op;
   assign op.erase  = want_erase;
   assign op.eeprom = region_select == REGN_EEPROM;
   assign op.addr   = nv_target_address;
   assign op.wdata  = program_write_data;

   // ----------------------------------------------------------------
   // Unlock key and time limit
   // ----------------------------------------------------------------
   // Any accepted command consumes the key; software rewrites it each time
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         key_count    <= RST_BYTE;
         prog_enabled <= 1'b0;
      end else if (ce_in) begin
         if (wr_key) begin
            key_count    <= wr_data_in;
            prog_enabled <= wr_data_in != RST_BYTE;
         end else if (start_op) begin
            key_count    <= RST_BYTE;
            prog_enabled <= 1'b0;
         end else if (prog_enabled) begin
            if (key_count == KEY_LAST) begin
               prog_enabled <= 1'b0;
            end
            key_count <= key_count - KEY_LAST;
         end
      end
   end

   // ----------------------------------------------------------------
   // Address, region and data registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         target_address_low  <= RST_BYTE;
         target_address_high <= '0;
      end else begin
         if (wr_addrl) begin
            target_address_low <= wr_data_in;
         end
         if (wr_addrh) begin
            target_address_high <= wr_data_in[HIGH_ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         region_select      <= RST_BYTE;
         program_write_data <= RST_BYTE;
      end else begin
         if (wr_regn) begin
            region_select <= wr_data_in;
         end
         if (wr_wdat) begin
            program_write_data <= wr_data_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         boot_area_select     <= 1'b0;
         sector_erase_request <= 1'b0;
         byte_program_request <= 1'b0;
         cmd_field            <= '0;
      end else if (ce_in) begin
         if (wr_ctl) begin
            boot_area_select     <= wr_data_in[CTL_BOOT_BIT];
            sector_erase_request <= wr_data_in[CTL_ERASE_BIT];
            byte_program_request <= wr_data_in[CTL_PROG_BIT];
            cmd_field            <= wr_data_in[CTL_CMD_MSB:CTL_CMD_LSB];
         end
         // A started operation clears its request so it cannot rerun
         if (start_op) begin
            sector_erase_request <= 1'b0;
            byte_program_request <= 1'b0;
            cmd_field            <= '0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port and status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rd_data_out <= RST_BYTE;
      end else if (ce_in) begin
         rd_data_out <= RST_BYTE;
         if (rd_strobe_in) begin
            case (addr_in)
               OFS_KEY:   rd_data_out <= key_count;
               OFS_ADDRL: rd_data_out <= target_address_low;
               OFS_ADDRH: rd_data_out <= {1'b0, target_address_high};
               OFS_REGN:  rd_data_out <= region_select;
               OFS_WDAT:  rd_data_out <= program_write_data;
               OFS_CTL: begin
                  rd_data_out[CTL_BOOT_BIT]  <= boot_area_select;
                  rd_data_out[CTL_ERASE_BIT] <= sector_erase_request;
                  rd_data_out[CTL_PROG_BIT]  <= byte_program_request;
                  rd_data_out[CTL_CMD_MSB:CTL_CMD_LSB] <= cmd_field;
               end
               default:   rd_data_out <= RST_BYTE;
            endcase
         end
      end
   end

   // Reset controller samples this level when it raises the core reset
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         boot_area_select_out <= 1'b0;
         prog_enabled_out     <= 1'b0;
         table_region_out     <= '0;
         table_region_ok_out  <= 1'b0;
      end else if (ce_in) begin
         boot_area_select_out <= boot_area_select;
         prog_enabled_out     <= prog_enabled;
         // Table reads see the low two bits; reserved codes flag not ok
         table_region_out     <= region_select[1:0];
         table_region_ok_out  <= (region_select <= REGN_BOOT);
      end
   end

   // ----------------------------------------------------------------
   // Operation engine
   // ----------------------------------------------------------------
   ipa_op_engine u_engine (
      .clock_in      (clock_in),
      .srst_in       (srst_in),
      .ce_in         (ce_in),
      .op            (op.eng),
      .nv_done_in    (nv_done_in),
      .nv_req_out    (nv_req_out),
      .nv_erase_out  (nv_erase_out),
      .nv_eeprom_out (nv_eeprom_out),
      .nv_addr_out   (nv_addr_out),
      .nv_wdata_out  (nv_wdata_out),
      .cpu_stall_out (cpu_stall_out)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_key_load;
      @(posedge clock_in) disable iff (srst_in)
      (wr_key && wr_data_in != RST_BYTE) |=>
         (prog_enabled && key_count == $past(wr_data_in));
   endproperty
   a_key_load: assert property (p_key_load)
      else $error("key write did not enable and load limit");

   property p_key_expire;
      @(posedge clock_in) disable iff (srst_in)
      (ce_in && prog_enabled && key_count == KEY_LAST &&
       !wr_key && !start_op) |=> !prog_enabled;
   endproperty
   a_key_expire: assert property (p_key_expire)
      else $error("enable survived its time limit");

   property p_key_count;
      @(posedge clock_in) disable iff (srst_in)
      (ce_in && prog_enabled && key_count > KEY_LAST &&
       !wr_key && !start_op) |=>
         (prog_enabled && key_count == $past(key_count) - KEY_LAST);
   endproperty
   a_key_count: assert property (p_key_count)
      else $error("limit counter did not step down");

   property p_addr_low;
      @(posedge clock_in) disable iff (srst_in)
      wr_addrl |=> nv_target_address[7:0] == $past(wr_data_in);
   endproperty
   a_addr_low: assert property (p_addr_low)
      else $error("low address not taken");

   property p_addr_high;
      @(posedge clock_in) disable iff (srst_in)
      wr_addrh |=> nv_target_address[14:8] == $past(wr_data_in[6:0]);
   endproperty
   a_addr_high: assert property (p_addr_high)
      else $error("high address not taken");

   property p_write_data;
      @(posedge clock_in) disable iff (srst_in)
      wr_wdat |=> program_write_data == $past(wr_data_in);
   endproperty
   a_write_data: assert property (p_write_data)
      else $error("data byte not taken");

   property p_start_region;
      @(posedge clock_in) disable iff (srst_in)
      start_op |=> (nv_req_out &&
                    nv_eeprom_out == ($past(region_select) == REGN_EEPROM));
   endproperty
   a_start_region: assert property (p_start_region)
      else $error("operation sent to wrong region");

   property p_no_ro_start;
      @(posedge clock_in) disable iff (srst_in)
      (cmd_go && (!prog_enabled || !writable_region)) |=> !nv_req_out;
   endproperty
   a_no_ro_start: assert property (p_no_ro_start)
      else $error("command accepted while locked or read only");

   property p_one_op;
      @(posedge clock_in) disable iff (srst_in)
      start_op |-> (want_erase != want_prog && cmd_go) ##1
         (!sector_erase_request && !byte_program_request &&
          nv_erase_out == $past(want_erase));
   endproperty
   a_one_op: assert property (p_one_op)
      else $error("start without a single operation");

   property p_boot_out;
      @(posedge clock_in) disable iff (srst_in)
      wr_ctl ##1 ce_in |=>
         boot_area_select_out == $past(wr_data_in[CTL_BOOT_BIT], 2);
   endproperty
   a_boot_out: assert property (p_boot_out)
      else $error("boot select not presented");

   c_erase: cover property (@(posedge clock_in) disable iff (srst_in)
      start_op && want_erase);
   c_program: cover property (@(posedge clock_in) disable iff (srst_in)
      start_op && want_prog && region_select == REGN_EEPROM);
   c_expire: cover property (@(posedge clock_in) disable iff (srst_in)
      prog_enabled ##1 !prog_enabled);

endmodule : ipa_regs

// ---- dv/ipa_nv_model.sv ----
// Behavioural model of the flash and data EEPROM controller
module ipa_nv_model (
   input  wire logic       clock_in,
   input  wire logic       srst_in,
   input  wire logic       nv_req_in,
   input  wire logic [3:0] lat_in,
   output logic            nv_done_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] cnt;

   // ----------------------------------------------------------------
   // Completion after a chosen delay, one-cycle done pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cnt         <= 4'h0;
         nv_done_out <= 1'b0;
      end else begin
         nv_done_out <= (cnt == 4'h1);
         if (nv_req_in) begin
            cnt <= lat_in;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : ipa_nv_model

// ---- dv/tb_inapp_program_access_regs.sv ----
// Self-checking bench for the programming register front end
module tb_inapp_program_access_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import ipa_pkg::*;

   logic        clock_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        ce_in = 1'b1;
   logic [7:0]  addr_in = 8'h00;
   logic [7:0]  wr_data_in = 8'h00;
   logic        wr_strobe_in = 1'b0;
   logic        rd_strobe_in = 1'b0;
   logic [7:0]  rd_data_out;
   logic        nv_done_in;
   logic        nv_req_out, nv_erase_out, nv_eeprom_out, cpu_stall_out;
   logic [14:0] nv_addr_out;
   logic [7:0]  nv_wdata_out;
   logic        boot_area_select_out, prog_enabled_out, table_region_ok_out;
   logic [1:0]  table_region_out;
   logic [3:0]  lat = 4'h1;
   logic        rd_pend = 1'b0;
   logic        idle_chk = 1'b0;
   logic [7:0]  rd_q[$];
   logic [24:0] op_q[$];
   int          n_mismatch = 0;
   int          n_checks = 0;
   integer      seed = 36;
   logic [31:0] r;
   logic [7:0]  v;

   always #4 clock_in = ~clock_in;

   ipa_regs i_dut (.clock_in(clock_in), .srst_in(srst_in), .ce_in(ce_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in),
      .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
      .rd_data_out(rd_data_out), .nv_done_in(nv_done_in),
      .nv_req_out(nv_req_out), .nv_erase_out(nv_erase_out),
      .nv_eeprom_out(nv_eeprom_out), .nv_addr_out(nv_addr_out),
      .nv_wdata_out(nv_wdata_out), .cpu_stall_out(cpu_stall_out),
      .boot_area_select_out(boot_area_select_out),
      .prog_enabled_out(prog_enabled_out),
      .table_region_out(table_region_out),
      .table_region_ok_out(table_region_ok_out));

   ipa_nv_model i_nv (.clock_in(clock_in), .srst_in(srst_in),
      .nv_req_in(nv_req_out), .lat_in(lat), .nv_done_out(nv_done_in));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [24:0] got, input logic [24:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk

   // Strobes stay up until the next task call, so no step lowers and
   // raises the same strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_in <= a;
      wr_data_in <= d;
      wr_strobe_in <= 1'b1;
      rd_strobe_in <= 1'b0;
      @(posedge clock_in);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      addr_in <= a;
      rd_strobe_in <= 1'b1;
      wr_strobe_in <= 1'b0;
      rd_q.push_back(exp);
      @(posedge clock_in);
   endtask : rd

   task automatic nop(input int n);
      wr_strobe_in <= 1'b0;
      rd_strobe_in <= 1'b0;
      repeat (n) @(posedge clock_in);
   endtask : nop

   task automatic tally_and_finish;
      if (rd_q.size() != 0 || op_q.size() != 0) n_mismatch++;
      if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // Output watcher: read data and operation requests against notes
   // ----------------------------------------------------------------
   always @(posedge clock_in) begin
      if (rd_pend) chk(25'(rd_data_out), 25'(rd_q.pop_front()));
      else if (idle_chk) chk(25'(rd_data_out), 25'h0);
      rd_pend <= rd_strobe_in && ce_in && !srst_in;
      idle_chk <= ce_in && !srst_in;
      if (nv_req_out === 1'b1) begin
         if (op_q.size() == 0) chk(25'h1, 25'h0);
         else chk({nv_erase_out, nv_eeprom_out, nv_addr_out, nv_wdata_out},
                  op_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clock_in);
      n_mismatch++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] hi, lo, rg;
      repeat (2) @(posedge clock_in);
      srst_in <= 1'b0;
      nop(2);
      for (int a = 8'hF0; a <= 8'hF7; a++) rd(8'(a), 8'h00);
      for (int a = 8'hF2; a <= 8'hF5; a++) begin
         r = $random(seed);
         wr(8'(a), r[7:0]);
         rd(8'(a), (a == 8'hF3) ? (r[7:0] & 8'h7F) : r[7:0]);
      end
      wr(8'hF0, 8'h5A);
      wr(8'hF7, 8'hA5);
      rd(8'hF0, 8'h00);
      rd(8'hF7, 8'h00);
      // Erase and program into both writable regions
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         hi = r[15:8];
         lo = r[7:0];
         v = r[23:16];
         rg = i[1] ? REGN_EEPROM : REGN_MAIN;
         lat <= 4'h1 + 4'(r[26:24]);
         wr(OFS_REGN, rg);
         wr(OFS_ADDRH, hi);
         wr(OFS_ADDRL, lo);
         wr(OFS_WDAT, v);
         wr(OFS_KEY, 8'h20);
         wr(OFS_CTL, i[0] ? 8'h20 : 8'h10);
         op_q.push_back({i[0], i[1], hi[6:0], lo, v});
         wr(OFS_CTL, 8'h02);
         nop(1);
         chk(25'(cpu_stall_out), 25'h1);
         for (int k = 0; k < 40 && cpu_stall_out !== 1'b0; k++) nop(1);
         nop(1);
         chk(25'(cpu_stall_out), 25'h0);
         rd(OFS_KEY, 8'h00);
         rd(OFS_CTL, 8'h00);
      end
      // Read-only, reserved and double-bit commands are dropped
      for (int i = 0; i < 6; i++) begin
         rg = (i >= 4) ? 8'h00 : ((i == 3) ? 8'h9C : 8'(i));
         if (i == 0) rg = REGN_UID;
         if (i == 2) rg = REGN_BOOT;
         wr(OFS_REGN, rg);
         wr(OFS_KEY, 8'h20);
         wr(OFS_CTL, (i == 4) ? 8'h30 : 8'h10);
         wr(OFS_CTL, (i == 5) ? 8'h13 : 8'h02);
         nop(3);
         chk(25'(cpu_stall_out), 25'h0);
         rd(OFS_CTL, (i == 5) ? 8'h13 : 8'h02);
         chk(25'(table_region_out), 25'(rg[1:0]));
         chk(25'(table_region_ok_out), 25'(rg <= 8'h03));
      end
      // Key runs out, then a command is ignored
      wr(OFS_KEY, 8'h00);
      wr(OFS_CTL, 8'h10);
      wr(OFS_KEY, 8'h03);
      nop(2);
      chk(25'(prog_enabled_out), 25'h1);
      nop(4);
      chk(25'(prog_enabled_out), 25'h0);
      wr(OFS_CTL, 8'h02);
      nop(3);
      chk(25'(cpu_stall_out), 25'h0);
      // Strobes are ignored while the clock enable is low
      wr(OFS_WDAT, 8'h3C);
      ce_in <= 1'b0;
      wr(OFS_WDAT, 8'hC3);
      ce_in <= 1'b1;
      rd(OFS_WDAT, 8'h3C);
      wr(OFS_CTL, 8'h80);
      nop(2);
      chk(25'(boot_area_select_out), 25'h1);
      rd(OFS_CTL, 8'h80);
      nop(3);
      tally_and_finish();
   end
endmodule : tb_inapp_program_access_regs
